/* File: core/nvw_consts.svh */
// Purpose: Address map, field values and sizes of the wiper page store.
// Assumes: Included by the design file only.
// Notes:   Wiper positions live in the last page of the array.
`ifndef NVW_CONSTS_SVH
`define NVW_CONSTS_SVH
`define NVW_DEV_PATTERN  6'h28
`define NVW_USER_LAST    8'hF7
`define NVW_WIPER_A_OFS  8'hF8
`define NVW_WIPER_B_OFS  8'hF9
`define NVW_WIPER_C_OFS  8'hFA
`define NVW_RSVD_FIRST   8'hFB
`define NVW_PAGE_LAST    3'h7
`define NVW_BIT_LAST     4'h7
`define NVW_BYTE_BITS    4'h8
`define NVW_ERASED       8'hFF
`define NVW_POS100_MASK  8'h7F
`define NVW_FIFO_DEPTH   8
`endif

/* File: core/nvw_pkg.sv */
// Purpose: Types shared by the wiper page store.
// Assumes: Nothing.
// Notes:   Offsets and counts are macros in nvw_consts.svh.
package nvw_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_DEV, ST_DEV_ACK, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK,
        ST_RDATA, ST_RACK, ST_COMMIT, ST_WIPE
    } link_state_e;
    typedef struct packed {
        logic [2:0] offset;
        logic [7:0] data;
    } wr_entry_s;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] c;
    } wiper_s;
endpackage

/* File: core/nv_wiper_eeprom_page_store.sv */
// Purpose: Two-wire slave with a paged nonvolatile store and three wiper bytes.
// Assumes: clk 200 MHz, serial clock far slower; rst_n is power-on reset.
// Notes:   Write data passes an 8-entry FIFO into the page staging buffer.
`timescale 1ns/1ps
`default_nettype none
`include "nvw_consts.svh"

module nvw_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0]      wr_ff;
    logic [AW:0]      rd_ff;
    logic [AW:0]      nxt_wr;
    logic [AW:0]      nxt_rd;

    assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
    assign out_valid = wr_ff != rd_ff;
    assign out_data  = store[rd_ff[AW-1:0]];

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        if (in_valid && in_ready) begin
            nxt_wr = wr_ff + 1'b1;
        end
        if (out_valid && out_ready) begin
            nxt_rd = rd_ff + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
        end
    end

    always_ff @(posedge clk) begin
        if (in_valid && in_ready) begin
            store[wr_ff[AW-1:0]] <= in_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Bytes 00h to F7h are plain user storage, freely written and read.
// - Bytes F8h, F9h, FAh hold the three wiper positions.
// - The array is thirty-two pages of eight bytes, 256 bytes in all.
// - Address upper five bits pick the page, lower three the byte.
// - The addressed page is copied to a staging buffer; serial data uses it.
// - Reads stage the whole page and move to the next page at its end.
// - Writes stage the start page and wrap the pointer within that page.
// - Stop after a write commits all eight staged bytes to the array.
// - No change to memory or wipers unless write-protect is low.
// - Data is sampled on serial clock rise and shifted out on fall.
// - The data pin is only pulled low or released, never driven high.
// - The select pin level is part of the device bus address.
// - Address is 101000, select bit, read/write bit; answer only on match.
// - Wiper A takes every value 00h to FFh.
// - Wipers B and C use 00h to 7Fh with the top bit ignored.
module nv_wiper_eeprom_page_store (
    // Clock and reset.
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Two-wire pins.
    input  wire logic            scl_in,
    input  wire logic            sda_in,
    output logic                 sda_out,
    output logic                 sda_oe_n,
    // Straps.
    input  wire logic            write_protect,
    input  wire logic            device_select_pin,
    // Wiper positions.
    output nvw_pkg::wiper_s      wiper_outputs
);
    import nvw_pkg::*;

    logic [1:0]        scl_sync_ff;
    logic [1:0]        sda_sync_ff;
    logic [1:0]        wp_sync_ff;
    logic [1:0]        sel_sync_ff;
    logic              scl_d_ff;
    logic              sda_d_ff;
    logic              scl_s;
    logic              sda_s;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    link_state_e       state_ff;
    link_state_e       nxt_state;
    logic [3:0]        cnt_ff;
    logic [3:0]        nxt_cnt;
    logic [1:0]        phase_ff;
    logic [1:0]        nxt_phase;
    logic [7:0]        shift_ff;
    logic [7:0]        nxt_shift;
    logic [7:0]        addr_ff;
    logic [7:0]        nxt_addr;
    logic              rw_ff;
    logic              nxt_rw;
    logic              ack_ok_ff;
    logic              nxt_ack_ok;
    logic              dirty_ff;
    logic              nxt_dirty;
    logic              oe_n_ff;
    logic              nxt_oe_n;
    logic              low_ff;
    wiper_s            wiper_ff;
    wiper_s            nxt_wiper;
    logic [7:0]        stage_ff [8];
    logic [7:0]        nxt_stage [8];
    logic [7:0]        nv_mem [256];
    logic              mem_we;
    logic [7:0]        mem_wa;
    logic              load_pg;
    logic [4:0]        load_page;
    logic [7:0]        byte_in;
    logic [7:0]        rd_byte;
    logic              push;
    wr_entry_s         push_entry;
    logic              f_in_ready;
    logic              f_valid;
    logic              f_pop;
    logic [10:0]       f_raw;
    wr_entry_s         f_out;

    ////////////////////////////////////////////////////////////////////////////
    // Pins cross two flops; edges are found one stage later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            wp_sync_ff  <= 2'h3;
            sel_sync_ff <= 2'h0;
            scl_d_ff    <= 1'b1;
            sda_d_ff    <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            wp_sync_ff  <= {wp_sync_ff[0], write_protect};
            sel_sync_ff <= {sel_sync_ff[0], device_select_pin};
            scl_d_ff    <= scl_sync_ff[1];
            sda_d_ff    <= sda_sync_ff[1];
        end
    end

    assign scl_s      = scl_sync_ff[1];
    assign sda_s      = sda_sync_ff[1];
    assign scl_rise   = scl_s && !scl_d_ff;
    assign scl_fall   = !scl_s && scl_d_ff;
    assign start_cond = scl_s && scl_d_ff && sda_d_ff && !sda_s;
    assign stop_cond  = scl_s && scl_d_ff && !sda_d_ff && sda_s;
    assign byte_in    = {shift_ff[6:0], sda_s};
    assign rd_byte    = stage_ff[addr_ff[2:0]];
    assign f_out      = wr_entry_s'(f_raw);
    assign f_pop      = f_valid && !load_pg;

    nvw_fifo #(.WIDTH($bits(wr_entry_s)), .DEPTH(`NVW_FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (push),
        .in_ready  (f_in_ready),
        .in_data   (push_entry),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_raw)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencing, staging and commit.
    always_comb begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff;
        nxt_phase  = phase_ff;
        nxt_shift  = shift_ff;
        nxt_addr   = addr_ff;
        nxt_rw     = rw_ff;
        nxt_ack_ok = ack_ok_ff;
        nxt_dirty  = dirty_ff;
        nxt_oe_n   = oe_n_ff;
        nxt_wiper  = wiper_ff;
        nxt_stage  = stage_ff;
        mem_we     = 1'b0;
        mem_wa     = {addr_ff[7:3], cnt_ff[2:0]};
        load_pg    = 1'b0;
        load_page  = addr_ff[7:3];
        push       = 1'b0;
        push_entry = '{offset: addr_ff[2:0], data: byte_in};
        case (state_ff)
            ST_WIPE: begin
                nxt_wiper.a = nv_mem[`NVW_WIPER_A_OFS];
                nxt_wiper.b = nv_mem[`NVW_WIPER_B_OFS] & `NVW_POS100_MASK;
                nxt_wiper.c = nv_mem[`NVW_WIPER_C_OFS] & `NVW_POS100_MASK;
                nxt_state   = ST_IDLE;
            end
            ST_COMMIT: begin
                // Inputs are ignored until the page is stored, so polling sees no answer.
                if (!f_valid) begin
                    mem_we  = 1'b1;
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff[2:0] == `NVW_PAGE_LAST) begin
                        nxt_cnt   = '0;
                        nxt_dirty = 1'b0;
                        nxt_state = ST_WIPE;
                    end
                end
            end
            default: begin
                if (stop_cond) begin
                    nxt_oe_n  = 1'b1;
                    nxt_cnt   = '0;
                    nxt_phase = '0;
                    nxt_state = (!rw_ff && dirty_ff) ? ST_COMMIT : ST_IDLE;
                end else if (start_cond) begin
                    nxt_oe_n  = 1'b1;
                    nxt_cnt   = '0;
                    nxt_phase = '0;
                    nxt_state = ST_DEV;
                end else begin
                    case (state_ff)
                        ST_DEV, ST_ADDR, ST_WDATA: begin
                            if (scl_rise) begin
                                nxt_shift = byte_in;
                                nxt_cnt   = cnt_ff + 1'b1;
                                if (cnt_ff == `NVW_BIT_LAST) begin
                                    nxt_cnt = '0;
                                    if (state_ff == ST_DEV) begin
                                        nxt_ack_ok = byte_in[7:1] ==
                                            {`NVW_DEV_PATTERN, sel_sync_ff[1]};
                                        nxt_rw     = byte_in[0];
                                        load_pg    = byte_in[0];
                                        nxt_state  = ST_DEV_ACK;
                                    end else if (state_ff == ST_ADDR) begin
                                        nxt_addr   = byte_in;
                                        load_page  = byte_in[7:3];
                                        load_pg    = 1'b1;
                                        nxt_dirty  = 1'b0;
                                        nxt_ack_ok = 1'b1;
                                        nxt_state  = ST_ADDR_ACK;
                                    end else begin
                                        // A full FIFO refuses the byte with no acknowledge.
                                        nxt_ack_ok = f_in_ready && !wp_sync_ff[1];
                                        push       = nxt_ack_ok;
                                        nxt_addr   = {addr_ff[7:3], addr_ff[2:0] + 3'h1};
                                        nxt_state  = ST_WACK;
                                    end
                                end
                            end
                        end
                        ST_DEV_ACK, ST_ADDR_ACK, ST_WACK: begin
                            if (phase_ff == 2'h0 && scl_fall) begin
                                nxt_oe_n  = !ack_ok_ff;
                                nxt_phase = 2'h1;
                            end else if (phase_ff == 2'h1 && scl_rise) begin
                                nxt_phase = 2'h2;
                            end else if (phase_ff == 2'h2 && scl_fall) begin
                                nxt_oe_n  = 1'b1;
                                nxt_phase = 2'h0;
                                nxt_state = ack_ok_ff ? ST_WDATA : ST_IDLE;
                                if (state_ff == ST_DEV_ACK && ack_ok_ff) begin
                                    nxt_state = rw_ff ? ST_RDATA : ST_ADDR;
                                    nxt_oe_n  = rw_ff ? rd_byte[7] : 1'b1;
                                end
                            end
                        end
                        ST_RDATA: begin
                            if (scl_rise) begin
                                nxt_cnt = cnt_ff + 1'b1;
                            end else if (scl_fall) begin
                                if (cnt_ff == `NVW_BYTE_BITS) begin
                                    nxt_oe_n  = 1'b1;
                                    nxt_cnt   = '0;
                                    nxt_addr  = addr_ff + 8'h01;
                                    load_page = nxt_addr[7:3];
                                    load_pg   = addr_ff[2:0] == `NVW_PAGE_LAST;
                                    nxt_state = ST_RACK;
                                end else begin
                                    nxt_oe_n = rd_byte[3'(`NVW_BIT_LAST - cnt_ff)];
                                end
                            end
                        end
                        ST_RACK: begin
                            if (scl_rise) begin
                                nxt_state = sda_s ? ST_IDLE : ST_RDATA;
                            end
                        end
                        default: begin
                            nxt_oe_n = 1'b1;
                        end
                    endcase
                end
            end
        endcase
        if (load_pg) begin
            for (int i = 0; i < 8; i++) begin
                nxt_stage[i] = nv_mem[{load_page, 3'(i)}];
            end
        end else if (f_pop) begin
            nxt_stage[f_out.offset] = f_out.data;
            nxt_dirty               = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff  <= ST_WIPE;
            cnt_ff    <= '0;
            phase_ff  <= '0;
            shift_ff  <= '0;
            addr_ff   <= '0;
            rw_ff     <= 1'b0;
            ack_ok_ff <= 1'b0;
            dirty_ff  <= 1'b0;
            oe_n_ff   <= 1'b1;
            low_ff    <= 1'b0;
            wiper_ff  <= '0;
            for (int i = 0; i < 8; i++) begin
                stage_ff[i] <= `NVW_ERASED;
            end
        end else begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            phase_ff  <= nxt_phase;
            shift_ff  <= nxt_shift;
            addr_ff   <= nxt_addr;
            rw_ff     <= nxt_rw;
            ack_ok_ff <= nxt_ack_ok;
            dirty_ff  <= nxt_dirty;
            oe_n_ff   <= nxt_oe_n;
            low_ff    <= 1'b0;
            wiper_ff  <= nxt_wiper;
            stage_ff  <= nxt_stage;
        end
    end

    // The array has no true retention here; reset stands in for an erased part.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                nv_mem[i] <= `NVW_ERASED;
            end
        end else if (mem_we) begin
            nv_mem[mem_wa] <= stage_ff[mem_wa[2:0]];
        end
    end

    assign sda_out       = low_ff;
    assign sda_oe_n      = oe_n_ff;
    assign wiper_outputs = wiper_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_pin_open_drain: assert property (!sda_oe_n |-> !sda_out)
        else $error("data pin driven high");
    chk_pin_fall_only: assert property ($fell(oe_n_ff) |-> $past(scl_fall))
        else $error("data pin pulled low off a falling clock edge");
    chk_wiper_top_bit: assert property (!wiper_ff.b[7] && !wiper_ff.c[7])
        else $error("100-position wiper top bit set");
    chk_wp_no_push: assert property (push |-> !wp_sync_ff[1])
        else $error("write accepted while protected");
    chk_page_wrap: assert property (push && addr_ff[2:0] == 3'h7
        |=> addr_ff == {$past(addr_ff[7:3]), 3'h0})
        else $error("write pointer left its page");
    chk_commit_len: assert property (state_ff == ST_COMMIT && !f_valid && cnt_ff == 4'h0
        |-> ##8 state_ff == ST_WIPE)
        else $error("page commit not eight cycles");
    chk_read_next_page: assert property (state_ff == ST_RDATA && load_pg
        |=> stage_ff[0] == nv_mem[{addr_ff[7:3], 3'h0}])
        else $error("read did not stage next page");
    chk_addr_match: assert property (state_ff == ST_DEV_ACK && !oe_n_ff
        |-> shift_ff[7:1] == {`NVW_DEV_PATTERN, sel_sync_ff[1]})
        else $error("acknowledged foreign address");
    chk_wiper_reload: assert property (state_ff == ST_WIPE
        |=> wiper_ff.a == nv_mem[`NVW_WIPER_A_OFS])
        else $error("wiper not reloaded");

    cov_commit: cover property (state_ff == ST_COMMIT ##[1:20] state_ff == ST_WIPE);
    cov_read_cross: cover property (state_ff == ST_RDATA && load_pg);
    cov_nack_addr: cover property (state_ff == ST_DEV_ACK && !ack_ok_ff && scl_fall);
endmodule
`default_nettype wire

/* File: verification/twi_master_model.sv */
// Purpose: Behavioural two-wire bus master that drives the serial clock.
// Assumes: The data wire has a pull-up; this master only pulls it low or lets go.
// Notes:   A quarter bit is 8 clk, so one serial clock period lasts 160 ns.
`timescale 1ns/1ps
`default_nettype none

module twi_master_model (
    // Clock.
    input  wire logic clk,
    // Two-wire lines.
    input  wire logic sda_wire,
    output var logic  scl,
    output var logic  sda_pull
);

    ////////////////////////////////////////////////////////////////////////////////
    // The clock stands high between frames, as a real master leaves it.
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Data bits change only in the middle of the clock low time; start and stop change data with the clock high.
    task automatic put_bit(input logic b);
        sda_pull <= ~b;
        idle(8);
        scl <= 1'b1;
        idle(16);
        scl <= 1'b0;
        idle(8);
    endtask

    // Sampling mid-high leaves the slave's three-cycle lag well behind.
    task automatic get_bit(output logic b);
        sda_pull <= 1'b0;
        idle(8);
        scl <= 1'b1;
        idle(8);
        b = sda_wire;
        idle(8);
        scl <= 1'b0;
        idle(8);
    endtask

    task automatic start_cond();
        sda_pull <= 1'b0;
        idle(8);
        scl <= 1'b1;
        idle(8);
        sda_pull <= 1'b1;
        idle(8);
        scl <= 1'b0;
        idle(8);
    endtask

    task automatic stop_cond();
        sda_pull <= 1'b1;
        idle(8);
        scl <= 1'b1;
        idle(8);
        sda_pull <= 1'b0;
        idle(8);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bytes go most significant bit first, then one acknowledge clock.
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(last);
    endtask

endmodule

`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the wiper page store over its serial link.
// Assumes: Select pin high unless a test says otherwise; array erased at reset.
// Notes:   Only user bytes and wiper bytes are written, never reserved ones.
`timescale 1ns/1ps
`default_nettype none

`define TB_EXPECT(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
    $display("Error at %0t ns: got %0h, expected %0h", $time, g, e); end end

module tb_top;
    import nvw_pkg::*;

    logic           clk;
    logic           rst_n;
    logic           write_protect;
    logic           device_select_pin;
    wire logic      scl;
    wire logic      sda_pull;
    wire logic      sda_wire;
    logic           sda_out;
    logic           sda_oe_n;
    wiper_s         wiper_outputs;
    int             fails;
    int             samples_checked;

    // Open-drain wire: low if either side pulls, else the pull-up wins.
    assign sda_wire = ~(sda_pull | ~sda_oe_n);

    nv_wiper_eeprom_page_store u_dut (
        .clk               (clk),
        .rst_n             (rst_n),
        .scl_in            (scl),
        .sda_in            (sda_wire),
        .sda_out           (sda_out),
        .sda_oe_n          (sda_oe_n),
        .write_protect     (write_protect),
        .device_select_pin (device_select_pin),
        .wiper_outputs     (wiper_outputs)
    );

    twi_master_model u_master (
        .clk      (clk),
        .sda_wire (sda_wire),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // The data pin may only ever pull low.
    always @(posedge clk) begin
        if (rst_n === 1'b1 && sda_oe_n === 1'b0) `TB_EXPECT(sda_out, 1'b0)
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Address byte is 101000, select bit, read/write bit.
    task automatic addr_only(input logic [7:0] dev, input logic exp_ack);
        logic ack;
        u_master.start_cond();
        u_master.send_byte(dev, ack);
        `TB_EXPECT(ack, exp_ack)
        u_master.stop_cond();
        u_master.idle(40);
    endtask

    // The pause after stop covers the page commit and the wiper reload.
    task automatic write_mem(input logic [7:0] addr, input logic [7:0] data[$],
                             input logic dat_ack);
        logic ack;
        u_master.start_cond();
        u_master.send_byte(8'hA2, ack);
        `TB_EXPECT(ack, 1'b1)
        u_master.send_byte(addr, ack);
        `TB_EXPECT(ack, 1'b1)
        foreach (data[i]) begin
            u_master.send_byte(data[i], ack);
            `TB_EXPECT(ack, dat_ack)
        end
        u_master.stop_cond();
        u_master.idle(40);
    endtask

    task automatic read_mem(input logic [7:0] addr, input logic [7:0] exp[$]);
        logic       ack;
        logic [7:0] d;
        u_master.start_cond();
        u_master.send_byte(8'hA2, ack);
        u_master.send_byte(addr, ack);
        `TB_EXPECT(ack, 1'b1)
        u_master.start_cond();
        u_master.send_byte(8'hA3, ack);
        `TB_EXPECT(ack, 1'b1)
        foreach (exp[i]) begin
            u_master.recv_byte(i == exp.size() - 1, d);
            `TB_EXPECT(d, exp[i])
        end
        u_master.stop_cond();
        u_master.idle(16);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n             = 1'b0;
        write_protect     = 1'b1;
        device_select_pin = 1'b1;
        fails             = 0;
        samples_checked   = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        `TB_EXPECT(wiper_outputs, 24'hFF7F7F)
        $display("test power_up done");
        write_protect <= 1'b0;
        // Nine bytes from offset 5 wrap round and overwrite offset 5.
        write_mem(8'h05, '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
                           8'h09}, 1'b1);
        read_mem(8'h00, '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h02, 8'h03,
                          8'hFF});
        $display("test page_wrap done");
        write_mem(8'hF8, '{8'hC3, 8'hE4, 8'hE3}, 1'b1);
        `TB_EXPECT(wiper_outputs, 24'hC36463)
        write_mem(8'hF7, '{8'h5A}, 1'b1);
        read_mem(8'hF7, '{8'h5A, 8'hC3, 8'hE4});
        read_mem(8'hFF, '{8'hFF, 8'h04});
        $display("test wipers done");
        write_protect <= 1'b1;
        write_mem(8'h05, '{8'hAA}, 1'b0);
        write_mem(8'hF8, '{8'h11}, 1'b0);
        read_mem(8'h05, '{8'h09});
        `TB_EXPECT(wiper_outputs, 24'hC36463)
        $display("test protect done");
        device_select_pin <= 1'b0;
        u_master.idle(8);
        addr_only(8'hA2, 1'b0);
        addr_only(8'hA0, 1'b1);
        addr_only(8'hE0, 1'b0);
        device_select_pin <= 1'b1;
        u_master.idle(8);
        addr_only(8'hA2, 1'b1);
        $display("test select done");
        end_of_test();
    end

    // Whole run needs about 17500 cycles.
    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        end_of_test();
    end

endmodule

`default_nettype wire
